// ### core/srcc_pkg.sv
package srcc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_MAIN_CONTROL = 8'h00;
    localparam logic [7:0] IDX_CAL_CLOCK_DIV = 8'h01;
    localparam logic [7:0] IDX_SEQ_CLOCK_EN = 8'h02;
    localparam logic [7:0] IDX_REF_DOUBLER = 8'h09;
    localparam logic [7:0] IDX_REF_REF_MULTIPLIER = 8'h0a;
    localparam logic [7:0] IDX_REF_DIVIDER = 8'h0b;
    localparam logic [7:0] IDX_PUMP_GAIN = 8'h0e;
    localparam int unsigned ADDR_LSB = 2;

    // ------------------------------------------------------------
    // Writable-bit masks per register
    // ------------------------------------------------------------
    localparam logic [15:0] MASK_MAIN_CONTROL = 16'h438f;
    localparam logic [15:0] MASK_CAL_CLOCK_DIV = 16'h0007;
    localparam logic [15:0] MASK_SEQ_CLOCK_EN = 16'h0400;
    localparam logic [15:0] MASK_REF_DOUBLER = 16'h1000;
    localparam logic [15:0] MASK_REF_REF_MULTIPLIER = 16'h0f80;
    localparam logic [15:0] MASK_REF_DIVIDER = 16'h0ff0;
    localparam logic [15:0] MASK_PUMP_GAIN = 16'h0070;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_MAIN_CONTROL = 16'h000c;
    localparam logic [15:0] RST_CAL_CLOCK_DIV = 16'h0003;
    localparam logic [15:0] RST_SEQ_CLOCK_EN = 16'h0000;
    localparam logic [15:0] RST_REF_DOUBLER = 16'h0000;
    localparam logic [15:0] RST_REF_REF_MULTIPLIER = 16'h0080;
    localparam logic [15:0] RST_REF_DIVIDER = 16'h0010;
    localparam logic [15:0] RST_PUMP_GAIN = 16'h0070;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned B_POWER_DOWN = 0;
    localparam int unsigned B_SOFT_RESET = 1;
    localparam int unsigned B_STATUS_SEL = 2;
    localparam int unsigned B_CAL_EN = 3;
    localparam int unsigned B_ADJ_LO = 7;
    localparam int unsigned B_AUTOMUTE = 9;
    localparam int unsigned B_DIV_SYNC = 14;
    localparam int unsigned B_SEQ_CLK_EN = 10;
    localparam int unsigned B_DOUBLER = 12;
    localparam int unsigned B_REF_MULTIPLIER_LO = 7;
    localparam int unsigned B_RDIV_LO = 4;
    localparam int unsigned B_GAIN_LO = 4;

    // Calibration run length in sequencer clock ticks
    localparam logic [7:0] CAL_TICKS = 8'h10;

endpackage

// ### core/srcc_regs.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
// Operation
// - Main control write starts calibration when enabled
// - Soft reset bit restores defaults, self-clears
// - Status pin: readback when 0, lock when 1
// - Automute mutes during calibration or unlock
// - Two-bit adjust selects calibration frequency range
// - Sync bit enables channel divider sync mode
// - Sequencer clock is oscillator over two^divider, over two at divider 0
// - Sequencer clock runs only when enabled
// - Doubler bit bypasses or inserts reference doubler
// - Eight-bit field sets reference R division
module srcc_regs
    import srcc_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RESET,
    input  wire logic              WB_CYC,
    input  wire logic              WB_STB,
    input  wire logic              WB_WE,
    input  wire logic [ADDR_W-1:0] WB_ADR,
    input  wire logic [3:0]        WB_SEL,
    input  wire logic [31:0]       WB_DAT_I,
    output logic      [31:0]       WB_DAT_O,
    output logic                   WB_ACK,
    input  wire logic              OSC_TICK,
    input  wire logic              LOCK_DETECT,
    input  wire logic              READBACK_DATA,
    output logic                   STATUS_PIN,
    output logic                   OUTPUT_MUTE,
    output logic                   CAL_BUSY,
    output logic                   SEQ_CLK,
    output logic      [1:0]        CAL_HIGH_PFD_ADJUST,
    output logic                   DIV_SYNC_MODE,
    output logic                   SYNTH_POWER_DOWN,
    output logic                   REF_DOUBLER_ENABLE,
    output logic      [4:0]        REF_MULTIPLIER,
    output logic      [7:0]        REF_DIVIDER,
    output logic      [2:0]        PUMP_GAIN
);
    import srcc_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Fewer address bits could not reach every register index;
    // elaboration stops rather than silently aliasing registers
    if (ADDR_W < 6) begin : g_chk
        $error("ADDR_W too small for register map");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // All state lives in one struct: one process computes the next
    // copy and one registers it, so nothing is driven twice
    typedef struct packed {
        logic [15:0] main_ctl;   // Main control word
        logic [15:0] clk_div;    // Sequencer clock divider
        logic [15:0] seq_en;     // Sequencer clock enable
        logic [15:0] dbl;        // Reference doubler
        logic [15:0] ref_multiplier;       // Reference multiplier
        logic [15:0] rdiv;       // Reference R divider
        logic [15:0] gain;       // Charge pump gain
        logic        ack;        // Bus acknowledge
        logic [31:0] rdata;      // Bus read data
        logic [6:0]  div_cnt;    // Oscillator tick prescaler
        logic        seq_clk;    // Divided sequencer clock
        logic        cal_busy;   // Calibration running
        logic [7:0]  cal_cnt;    // Remaining calibration ticks
        logic        status;     // Status pin level
        logic        mute;       // Output mute level
    } srcc_state_t;

    // Present and next state
    srcc_state_t st;
    srcc_state_t next_st;

    // Register decode used by the read path
    function automatic logic [15:0] srcc_read(
        input srcc_state_t s,
        input logic [7:0]  idx
    );
        logic [15:0] v;
        v = 16'h0000;
        unique case (idx)
            IDX_MAIN_CONTROL:  v = s.main_ctl;
            IDX_CAL_CLOCK_DIV: v = s.clk_div;
            IDX_SEQ_CLOCK_EN:  v = s.seq_en;
            IDX_REF_DOUBLER:   v = s.dbl;
            IDX_REF_REF_MULTIPLIER:      v = s.ref_multiplier;
            IDX_REF_DIVIDER:   v = s.rdiv;
            IDX_PUMP_GAIN:     v = s.gain;
            // Unmapped indices read zero; reserved bits are never stored
            default:           v = 16'h0000;
        endcase
        return v;
    endfunction

    // Byte-lane merge restricted to the writable mask
    function automatic logic [15:0] srcc_merge(
        input logic [15:0] old,
        input logic [15:0] wd,
        input logic [1:0]  sel,
        input logic [15:0] mask
    );
        logic [15:0] lanes;
        // A lane without its select bit keeps its old contents
        lanes = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        return (old & ~lanes) | (wd & lanes);
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // A request is taken on the edge that sees cyc and stb with ack
    // low; ack follows one cycle later and drops on the next edge,
    // so every access costs exactly two cycles. Writes land at the
    // taken edge, one edge before the master samples ack.
    logic [7:0]  idx;
    logic        wr;
    logic        tick;
    logic [6:0]  div_limit;
    logic [15:0] wd;

    // Index from the byte address; the two lane bits are dropped
    assign idx = 8'(WB_ADR[ADDR_W-1:ADDR_LSB]);
    assign wd  = WB_DAT_I[15:0];
    // Single-cycle strobe: ack is dropped the cycle after it is given
    assign wr  = WB_CYC && WB_STB && WB_WE && !st.ack;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Order matters below: later assignments override earlier ones,
    // with soft reset the strongest
    always_comb begin
        next_st = st;
        // Ack pulses once per request; the second cycle sees it high
        next_st.ack = WB_CYC && WB_STB && !st.ack;
        // Read data is captured at the taken edge and then held
        if (WB_CYC && WB_STB && !st.ack && !WB_WE) begin
            next_st.rdata = {16'h0000, srcc_read(st, idx)};
        end
        if (wr) begin
            unique case (idx)
                IDX_MAIN_CONTROL: begin
                    next_st.main_ctl = srcc_merge(st.main_ctl, wd,
                        WB_SEL[1:0], MASK_MAIN_CONTROL);
                end
                IDX_CAL_CLOCK_DIV: begin
                    next_st.clk_div = srcc_merge(st.clk_div, wd,
                        WB_SEL[1:0], MASK_CAL_CLOCK_DIV);
                end
                IDX_SEQ_CLOCK_EN: begin
                    next_st.seq_en = srcc_merge(st.seq_en, wd,
                        WB_SEL[1:0], MASK_SEQ_CLOCK_EN);
                end
                IDX_REF_DOUBLER: begin
                    next_st.dbl = srcc_merge(st.dbl, wd,
                        WB_SEL[1:0], MASK_REF_DOUBLER);
                end
                IDX_REF_REF_MULTIPLIER: begin
                    next_st.ref_multiplier = srcc_merge(st.ref_multiplier, wd,
                        WB_SEL[1:0], MASK_REF_REF_MULTIPLIER);
                end
                IDX_REF_DIVIDER: begin
                    next_st.rdiv = srcc_merge(st.rdiv, wd,
                        WB_SEL[1:0], MASK_REF_DIVIDER);
                end
                IDX_PUMP_GAIN: begin
                    next_st.gain = srcc_merge(st.gain, wd,
                        WB_SEL[1:0], MASK_PUMP_GAIN);
                end
                // Unmapped: write ignored, still acked
                // so a stray access never stalls the bus
                default: begin
                end
            endcase
        end
        // calibration trigger on control write
        // A rewrite with the enable bit set during a run restarts the count from the top; the
        // run needs the sequencer clock enabled, or it never ends
        if (wr && idx == IDX_MAIN_CONTROL &&
            next_st.main_ctl[B_CAL_EN]) begin
            next_st.cal_busy = 1'b1;
            next_st.cal_cnt  = CAL_TICKS;
        end else if (st.cal_busy && tick) begin
            // Run advances on sequencer clock rising edges
            next_st.cal_cnt = st.cal_cnt - 8'h01;
            // Count reaching one ends the run on this sequencer edge
            if (st.cal_cnt == 8'h01) begin
                next_st.cal_busy = 1'b0;
            end
        end
        // gated by sequencer enable
        // Count wraps at the half period, toggling the clock
        if (st.seq_en[B_SEQ_CLK_EN] && OSC_TICK) begin
            if (st.div_cnt >= div_limit) begin
                next_st.div_cnt = 7'h00;
                next_st.seq_clk = ~st.seq_clk;
            end else begin
                next_st.div_cnt = st.div_cnt + 7'h01;
            end
        end else if (!st.seq_en[B_SEQ_CLK_EN]) begin
            // Disabled: counter and clock parked low for a clean start
            next_st.div_cnt = 7'h00;
            next_st.seq_clk = 1'b0;
        end
        next_st.status = st.main_ctl[B_STATUS_SEL] ? LOCK_DETECT
                                                   : READBACK_DATA;
        // automute on calibration or unlock
        // Next busy level, so mute also covers the first busy cycle
        next_st.mute = st.main_ctl[B_AUTOMUTE] &&
                       (next_st.cal_busy || !LOCK_DETECT);
        // soft reset restores defaults, bit self-clears
        // Placed last so it overrides the write merge and the trigger
        if (wr && idx == IDX_MAIN_CONTROL && wd[B_SOFT_RESET] &&
            WB_SEL[0]) begin
            next_st.main_ctl = RST_MAIN_CONTROL;
            next_st.clk_div  = RST_CAL_CLOCK_DIV;
            next_st.seq_en   = RST_SEQ_CLOCK_EN;
            next_st.dbl      = RST_REF_DOUBLER;
            next_st.ref_multiplier     = RST_REF_REF_MULTIPLIER;
            next_st.rdiv     = RST_REF_DIVIDER;
            next_st.gain     = RST_PUMP_GAIN;
            next_st.cal_busy = 1'b0;
            next_st.cal_cnt  = 8'h00;
        end
    end

    // Half-period of 2^(div-1) oscillator ticks; div 0 toggles on each tick, like div 1
    // A three-bit field caps the half period at 64 ticks
    always_comb begin
        div_limit = 7'h00;
        if (st.clk_div[2:0] != 3'h0) begin
            div_limit = 7'((8'h01 << (st.clk_div[2:0] - 3'h1)) - 8'h01);
        end
    end

    // ------------------------------------------------------------
    // Sequencer clock edge
    // ------------------------------------------------------------
    // Rising edge of the sequencer clock, one system cycle wide.
    // Decoded from the present state and OSC_TICK, so that the next-state
    // process, which reads it, never feeds back on itself.
    // Limitation: ratio 0 still gives half the tick rate, since a
    // registered clock cannot toggle twice per system cycle.
    assign tick = st.seq_en[B_SEQ_CLK_EN] && OSC_TICK &&
                  (st.div_cnt >= div_limit) && !st.seq_clk;

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Synchronous reset: the struct clears, then the register words
    // take their power-on defaults
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            st          <= '0;
            st.main_ctl <= RST_MAIN_CONTROL;
            st.clk_div  <= RST_CAL_CLOCK_DIV;
            st.seq_en   <= RST_SEQ_CLOCK_EN;
            st.dbl      <= RST_REF_DOUBLER;
            st.ref_multiplier     <= RST_REF_REF_MULTIPLIER;
            st.rdiv     <= RST_REF_DIVIDER;
            st.gain     <= RST_PUMP_GAIN;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from state
    // ------------------------------------------------------------
    // Every output is a flip-flop or a slice of one; status and mute
    // lag their pin inputs by one cycle for that reason
    assign WB_DAT_O            = st.rdata;
    assign WB_ACK              = st.ack;
    assign STATUS_PIN          = st.status;
    assign OUTPUT_MUTE         = st.mute;
    assign CAL_BUSY            = st.cal_busy;
    assign SEQ_CLK             = st.seq_clk;
    assign CAL_HIGH_PFD_ADJUST = st.main_ctl[B_ADJ_LO +: 2];
    assign DIV_SYNC_MODE       = st.main_ctl[B_DIV_SYNC];
    // Power down is a plain level; no logic in this block reads it
    assign SYNTH_POWER_DOWN    = st.main_ctl[B_POWER_DOWN];
    assign REF_DOUBLER_ENABLE  = st.dbl[B_DOUBLER];
    // Multiplier codes pass as written; software keeps them legal
    assign REF_MULTIPLIER      = st.ref_multiplier[B_REF_MULTIPLIER_LO +: 5];
    assign REF_DIVIDER         = st.rdiv[B_RDIV_LO +: 8];
    assign PUMP_GAIN           = st.gain[B_GAIN_LO +: 3];

endmodule

// ### dv/srcc_monitor.sv
`timescale 1ns/100ps
module srcc_monitor
    import srcc_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic              CLK_SYS,
    input wire logic              RESET,
    input wire logic              WB_CYC,
    input wire logic              WB_STB,
    input wire logic              WB_WE,
    input wire logic [ADDR_W-1:0] WB_ADR,
    input wire logic [3:0]        WB_SEL,
    input wire logic [31:0]       WB_DAT_I,
    input wire logic              WB_ACK,
    input wire logic              LOCK_DETECT,
    input wire logic              READBACK_DATA,
    input wire logic              STATUS_PIN,
    input wire logic              OUTPUT_MUTE,
    input wire logic              CAL_BUSY,
    input wire logic              SEQ_CLK,
    input wire logic [1:0]        CAL_HIGH_PFD_ADJUST,
    input wire logic              DIV_SYNC_MODE,
    input wire logic              SYNTH_POWER_DOWN
);
    // ------------------------------------------------------------
    // Shadow of main control and sequencer enable
    // ------------------------------------------------------------
    logic        take;        // Write taken at this edge
    logic        mw;          // Taken write to main control, low lane
    logic [15:0] sh, sh_q;    // Main control and its one-cycle-late copy
    logic        en, en_q;    // Sequencer clock enable copy
    logic        lk_q, rb_q;  // Pin inputs one cycle late
    assign take = WB_CYC && WB_STB && WB_WE && !WB_ACK;
    assign mw   = take && WB_ADR[7:2] == 6'h00 && WB_SEL[0];
    // Soft reset clears the shadow exactly like a full reset
    always_ff @(posedge CLK_SYS) begin
        sh_q <= sh;
        en_q <= en;
        lk_q <= LOCK_DETECT;
        rb_q <= READBACK_DATA;
        if (RESET || (mw && WB_DAT_I[1])) begin
            sh <= RST_MAIN_CONTROL;
            en <= 1'b0;
        end else if (take && WB_ADR[7:2] == 6'h00) begin
            if (WB_SEL[0]) begin
                sh[7:0] <= WB_DAT_I[7:0] & MASK_MAIN_CONTROL[7:0];
            end
            if (WB_SEL[1]) begin
                sh[15:8] <= WB_DAT_I[15:8] & MASK_MAIN_CONTROL[15:8];
            end
        end else if (take && WB_ADR[7:2] == 6'h02 && WB_SEL[1]) begin
            en <= WB_DAT_I[10];
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    sequence cal_wr;
        mw && WB_DAT_I[3] && !WB_DAT_I[1];
    endsequence
    sequence soft_wr;
        mw && WB_DAT_I[1];
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    cal_start_a: assert property (cal_wr |-> ##[1:2] CAL_BUSY)
        else $error("calibration did not start");
    cal_quiet_a: assert property (mw && !WB_DAT_I[3] && !CAL_BUSY
        |=> !CAL_BUSY [*2]) else $error("calibration started while off");
    soft_reset_a: assert property (soft_wr |=> !$rose(CAL_BUSY)
        ##1 (!SYNTH_POWER_DOWN && !DIV_SYNC_MODE)) else $error("soft reset");
    status_route_a: assert property (!$past(RESET)
        |-> STATUS_PIN == (sh_q[2] ? lk_q : rb_q)) else $error("status pin");
    mute_off_a: assert property (!sh[9] && !sh_q[9] && !$past(RESET)
        |-> !OUTPUT_MUTE) else $error("mute while automute off");
    mute_unlock_a: assert property (sh[9] && sh_q[9] && !lk_q
        && !$past(RESET) |-> OUTPUT_MUTE) else $error("no mute when unlocked");
    adjust_field_a: assert property (sh == sh_q
        |-> CAL_HIGH_PFD_ADJUST == sh[8:7]) else $error("adjust field");
    sync_field_a: assert property (sh == sh_q
        |-> DIV_SYNC_MODE == sh[14] && SYNTH_POWER_DOWN == sh[0])
        else $error("sync or power down field");
    seq_idle_a: assert property (!en && !en_q |-> !SEQ_CLK)
        else $error("sequencer clock runs while disabled");
endmodule
bind srcc_regs srcc_monitor #(.ADDR_W(ADDR_W)) u_srcc_monitor (.*);

// ### dv/test_synth_ref_cal_control_regs.sv
`timescale 1ns/100ps
module test_synth_ref_cal_control_regs;
    import srcc_pkg::*;
    logic        CLK_SYS = 1'b0, RESET = 1'b1, WB_CYC = 1'b0, WB_STB = 1'b0;
    logic        WB_WE = 1'b0, OSC_TICK = 1'b1, LOCK_DETECT = 1'b1;
    logic        READBACK_DATA = 1'b0, WB_ACK, STATUS_PIN, OUTPUT_MUTE;
    logic        CAL_BUSY, SEQ_CLK, DIV_SYNC_MODE, SYNTH_POWER_DOWN;
    logic        REF_DOUBLER_ENABLE;
    logic [7:0]  WB_ADR = 8'h00, REF_DIVIDER;
    logic [3:0]  WB_SEL = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rdata;
    logic [1:0]  CAL_HIGH_PFD_ADJUST;
    logic [4:0]  REF_MULTIPLIER;
    logic [2:0]  PUMP_GAIN;
    logic [15:0] wv;           // Write value of the mask sweep
    int          n_errors = 0, checks_done = 0, c;
    // Register table: index, reset value, writable mask
    logic [5:0]  ix [7] = '{6'h00, 6'h01, 6'h02, 6'h09, 6'h0a, 6'h0b, 6'h0e};
    logic [15:0] df [7] = '{RST_MAIN_CONTROL, RST_CAL_CLOCK_DIV,
        RST_SEQ_CLOCK_EN, RST_REF_DOUBLER, RST_REF_REF_MULTIPLIER, RST_REF_DIVIDER,
        RST_PUMP_GAIN};
    logic [15:0] mk [7] = '{MASK_MAIN_CONTROL, MASK_CAL_CLOCK_DIV,
        MASK_SEQ_CLOCK_EN, MASK_REF_DOUBLER, MASK_REF_REF_MULTIPLIER, MASK_REF_DIVIDER,
        MASK_PUMP_GAIN};
    int          mv [6] = '{1, 3, 4, 5, 6, 7};  // Legal multiplier codes
    srcc_regs u_srcc_regs (.*);
    initial begin
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    // One classic cycle; bounded wait so a dead slave cannot hang the run
    task automatic bus(input logic we, input logic [5:0] a,
                       input logic [15:0] d, input logic [3:0] s);
        int n;
        @(posedge CLK_SYS);
        WB_CYC   <= 1'b1;
        WB_STB   <= 1'b1;
        WB_WE    <= we;
        WB_ADR   <= {a, 2'b00};
        WB_SEL   <= s;
        WB_DAT_I <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (WB_ACK !== 1'b1 && n < 20);
        rdata = WB_DAT_O;
        WB_CYC <= 1'b0;
        WB_STB <= 1'b0;
        chk(32'(WB_ACK), 1);
        if (WB_ACK !== 1'b1) test_done();
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000, 4'hf);
        chk(rdata, {16'h0000, exp});
    endtask
    task automatic defaults;
        for (int i = 0; i < 7; i++) rd(ix[i], df[i]);
    endtask
    // Waits for a rising edge of the sequencer clock
    task automatic edge_up(inout int c);
        while (SEQ_CLK !== 1'b0 && c < 300) begin
            @(posedge CLK_SYS);
            c++;
        end
        while (SEQ_CLK !== 1'b1 && c < 300) begin
            @(posedge CLK_SYS);
            c++;
        end
        if (c >= 300) begin
            n_errors++;
            $display("wrong value at %0t: sequencer edge timeout", $time);
            test_done();
        end
    endtask
    initial begin
        tick(20);
        RESET <= 1'b0;
        defaults();
        $display("test defaults done");
        tick(2);
        chk(32'(STATUS_PIN), 1);
        LOCK_DETECT <= 1'b0;
        tick(3);
        chk(32'(STATUS_PIN), 0);
        bus(1'b1, 6'h00, 16'h0000, 4'h3);
        tick(2);
        chk(32'(CAL_BUSY), 0);
        READBACK_DATA <= 1'b1;
        tick(3);
        chk(32'(STATUS_PIN), 1);
        LOCK_DETECT <= 1'b1;
        $display("test status pin done");
        for (int i = 1; i < 7; i++) begin
            wv = (ix[i] == 6'h0a) ? 16'hf3ff : 16'hffff;
            bus(1'b1, ix[i], wv, 4'h3);
            rd(ix[i], mk[i] & wv);
        end
        bus(1'b1, 6'h00, 16'hfffd, 4'h3);
        tick(2);
        chk(32'(CAL_BUSY), 1);
        chk(32'(OUTPUT_MUTE), 1);
        rd(6'h00, 16'h438d);
        chk(32'({REF_DOUBLER_ENABLE, REF_MULTIPLIER, REF_DIVIDER, PUMP_GAIN}),
            32'h13fff);
        chk(32'({CAL_HIGH_PFD_ADJUST, DIV_SYNC_MODE, SYNTH_POWER_DOWN}),
            32'hf);
        c = 0;
        while (CAL_BUSY !== 1'b0 && c < 4000) begin
            @(posedge CLK_SYS);
            c++;
        end
        chk(32'(CAL_BUSY), 0);
        if (CAL_BUSY !== 1'b0) test_done();
        tick(3);
        chk(32'(OUTPUT_MUTE), 0);
        LOCK_DETECT <= 1'b0;
        tick(3);
        chk(32'(OUTPUT_MUTE), 1);
        LOCK_DETECT <= 1'b1;
        // unmapped indices are read, never written
        rd(6'h03, 16'h0000);
        rd(6'h3f, 16'h0000);
        $display("test calibration done");
        for (int d = 1; d < 4; d++) begin
            bus(1'b1, 6'h01, 16'(d), 4'h1);
            c = 0;
            edge_up(c);
            c = 0;
            edge_up(c);
            chk(32'(c), 32'(1 << d));
        end
        bus(1'b1, 6'h02, 16'h0000, 4'h3);
        tick(3);
        chk(32'(SEQ_CLK), 0);
        $display("test sequencer clock done");
        bus(1'b1, 6'h0b, 16'habcd, 4'h2);
        rd(6'h0b, 16'h0bf0);
        chk(32'(REF_DIVIDER), 32'hbf);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, 6'h0a, 16'(mv[i] << 7), 4'h3);
            tick(1);
            chk(32'(REF_MULTIPLIER), 32'(mv[i]));
        end
        bus(1'b1, 6'h09, 16'h0000, 4'h3);
        tick(1);
        chk(32'(REF_DOUBLER_ENABLE), 0);
        $display("test reference path done");
        // Enable bit set too: soft reset must still start no run
        bus(1'b1, 6'h00, 16'h000a, 4'h1);
        tick(2);
        chk(32'(CAL_BUSY), 0);
        defaults();
        $display("test soft reset done");
        test_done();
    end
endmodule
